/* File: mhc_pkg.sv */
// Package with constants and types for the maintenance hours counter.
package mhc_pkg;

	// Clock rate and time base.
	// A minute holds more cycles than 32 bits can count, so these are 64-bit.
	localparam longint unsigned CLOCK_HZ      = 250_000_000;
	localparam longint unsigned MINUTE_S      = 60;
	localparam longint unsigned MINUTE_CYCLES = CLOCK_HZ * MINUTE_S;

	// Value ranges.
	localparam int unsigned INTERVAL_HOURS_MAX = 9999;
	localparam int unsigned TOTAL_HOURS_MAX    = 99999;
	localparam int unsigned MINUTES_MAX        = 59;
	localparam int unsigned MINUTES_PER_HOUR   = 60;

	// Field widths.
	localparam int unsigned INTERVAL_HOURS_W = 14;
	localparam int unsigned TOTAL_HOURS_W    = 17;
	localparam int unsigned MINUTES_W        = 6;
	localparam int unsigned INTERVAL_MIN_W   = 20;
	localparam int unsigned TOTAL_MIN_W      = 23;

	// Values after reset.
	localparam logic [TOTAL_MIN_W-1:0]    TOTAL_RESET    = 23'h000000;
	localparam logic [INTERVAL_MIN_W-1:0] TOGO_RESET     = 20'h00000;
	localparam logic                      MAINT_RESET    = 1'h0;

	// Clearing modes of the maintenance output.
	typedef enum logic [0:0] {
		CLEAR_RESET_ONLY   = 1'b0,
		CLEAR_RESET_OR_MON = 1'b1
	} mhc_clear_mode_e;

	// Phases of the power-up load sequence.
	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_DIVIDE = 2'b01,
		PH_RUN    = 2'b10
	} mhc_phase_e;

endpackage : mhc_pkg

/* File: mhc_minute_tick.sv */
// Minute tick generator that counts clock cycles only while enabled.
`timescale 1ns/1ps
module mhc_minute_tick #(
	parameter longint unsigned CYCLES = mhc_pkg::MINUTE_CYCLES
) (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic reset,
	// Control.
	input  wire logic enable,
	input  wire logic restart,
	// Result.
	output logic      tick
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_tick;

	// Partial minutes are kept while the input is low, so on-time adds up exactly.
	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (restart) begin
			next_count = '0;
		end else if (enable) begin
			if (count == LAST) begin
				next_count = '0;
				next_tick  = 1'b1;
			end else begin
				next_count = count + CW'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : mhc_minute_tick

/* File: mhc_remainder.sv */
// Sequential restoring divider that yields the remainder of total over interval.
`timescale 1ns/1ps
module mhc_remainder #(
	parameter int unsigned NW = mhc_pkg::TOTAL_MIN_W,
	parameter int unsigned DW = mhc_pkg::INTERVAL_MIN_W
) (
	// Clock and reset.
	input  wire logic          clock,
	input  wire logic          reset,
	// Request.
	input  wire logic          start,
	input  wire logic [NW-1:0] dividend,
	input  wire logic [DW-1:0] divisor,
	// Answer.
	output logic               done,
	output logic [DW-1:0]      remainder
);
	localparam int unsigned SW = $clog2(NW + 1);

	logic [NW-1:0] quot;
	logic [DW:0]   rem;
	logic [SW-1:0] steps;
	logic          busy;
	logic [NW-1:0] next_quot;
	logic [DW:0]   next_rem;
	logic [SW-1:0] next_steps;
	logic          next_busy;
	logic          next_done;
	logic [DW:0]   trial;

	always_comb begin
		next_quot  = quot;
		next_rem   = rem;
		next_steps = steps;
		next_busy  = busy;
		next_done  = 1'b0;
		trial      = {rem[DW-1:0], quot[NW-1]};
		if (start) begin
			next_quot  = dividend;
			next_rem   = '0;
			next_steps = SW'(NW);
			next_busy  = 1'b1;
		end else if (busy) begin
			next_quot = {quot[NW-2:0], 1'b0};
			if (trial >= {1'b0, divisor}) begin
				next_rem = trial - {1'b0, divisor};
			end else begin
				next_rem = trial;
			end
			next_steps = steps - SW'(1);
			if (steps == SW'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			quot  <= '0;
			rem   <= '0;
			steps <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			quot  <= next_quot;
			rem   <= next_rem;
			steps <= next_steps;
			busy  <= next_busy;
			done  <= next_done;
		end
	end

	assign remainder = rem[DW-1:0];
endmodule : mhc_remainder

/* File: mhc_hours_counter.sv */
// Maintenance hours counter: operating total, time-to-go and maintenance output.
`timescale 1ns/1ps
module mhc_hours_counter #(
	parameter longint unsigned MINUTE_CYCLES = mhc_pkg::MINUTE_CYCLES
) (
	// Clock and reset.
	input  wire logic                                 clock,
	input  wire logic                                 reset,
	// Program inputs.
	input  wire logic                                 monitorIn,
	input  wire logic                                 partialReset,
	input  wire logic                                 fullReset,
	// Configuration.
	input  wire logic                                 clearMode,
	input  wire logic [mhc_pkg::INTERVAL_HOURS_W-1:0] intervalHours,
	input  wire logic [mhc_pkg::MINUTES_W-1:0]        intervalMinutes,
	input  wire logic [mhc_pkg::TOTAL_HOURS_W-1:0]    offsetHours,
	input  wire logic [mhc_pkg::MINUTES_W-1:0]        offsetMinutes,
	// Retained values restored at power-up.
	input  wire logic                                 retainValid,
	input  wire logic [mhc_pkg::TOTAL_MIN_W-1:0]      retainTotal,
	input  wire logic [mhc_pkg::INTERVAL_MIN_W-1:0]   retainToGo,
	// Outputs.
	output logic                                      maintenance,
	output logic [mhc_pkg::TOTAL_MIN_W-1:0]           operatingTotal,
	output logic [mhc_pkg::INTERVAL_MIN_W-1:0]        timeToGo,
	output logic [mhc_pkg::INTERVAL_MIN_W-1:0]        maintenanceInterval,
	output logic                                      running
);
	localparam int unsigned TW = mhc_pkg::TOTAL_MIN_W;
	localparam int unsigned IW = mhc_pkg::INTERVAL_MIN_W;

	// Clamps an hours and minutes pair and converts it to minutes.
	function automatic logic [TW-1:0] to_minutes(input logic [mhc_pkg::TOTAL_HOURS_W-1:0] hrs,
						      input logic [mhc_pkg::MINUTES_W-1:0] mins,
						      input logic [mhc_pkg::TOTAL_HOURS_W-1:0] hrsMax);
		logic [mhc_pkg::TOTAL_HOURS_W-1:0] h;
		logic [mhc_pkg::MINUTES_W-1:0]     m;
		h = (hrs > hrsMax) ? hrsMax : hrs;
		m = (mins > mhc_pkg::MINUTES_W'(mhc_pkg::MINUTES_MAX)) ? mhc_pkg::MINUTES_W'(mhc_pkg::MINUTES_MAX) : mins;
		to_minutes = TW'(h) * TW'(mhc_pkg::MINUTES_PER_HOUR) + TW'(m);
	endfunction : to_minutes

	localparam logic [TW-1:0] TOTAL_LIMIT = TW'(mhc_pkg::TOTAL_HOURS_MAX * mhc_pkg::MINUTES_PER_HOUR);

	mhc_pkg::mhc_phase_e phase;
	mhc_pkg::mhc_phase_e next_phase;
	logic [TW-1:0]       next_operatingTotal;
	logic [IW-1:0]       next_timeToGo;
	logic [IW-1:0]       next_maintenanceInterval;
	logic                next_maintenance;
	logic                next_running;
	logic                partialPrev;
	logic                fullPrev;
	logic                minuteTick;
	logic                divStart;
	logic                divDone;
	logic [IW-1:0]       divRemainder;
	logic [IW-1:0]       intervalNow;
	logic                partialEdge;
	logic                fullEdge;

	assign intervalNow = IW'(to_minutes(mhc_pkg::TOTAL_HOURS_W'(intervalHours), intervalMinutes,
					     mhc_pkg::TOTAL_HOURS_W'(mhc_pkg::INTERVAL_HOURS_MAX)));
	assign partialEdge = partialReset & ~partialPrev;
	assign fullEdge    = fullReset & ~fullPrev;
	assign divStart    = (phase == mhc_pkg::PH_IDLE) && !retainValid;

	// Elapsed time counts only while monitoring is high; a full reset edge restarts the partial minute.
	mhc_minute_tick #(
		.CYCLES (MINUTE_CYCLES)
	) u_tick (
		.clock   (clock),
		.reset   (reset),
		.enable  (monitorIn && phase == mhc_pkg::PH_RUN),
		.restart (fullEdge),
		.tick    (minuteTick)
	);

	// The power-up time-to-go needs total modulo interval, done once by a slow divider.
	mhc_remainder #(
		.NW (TW),
		.DW (IW)
	) u_rem (
		.clock     (clock),
		.reset     (reset),
		.start     (divStart),
		.dividend  (to_minutes(offsetHours, offsetMinutes, mhc_pkg::TOTAL_HOURS_W'(mhc_pkg::TOTAL_HOURS_MAX))),
		.divisor   (intervalNow),
		.done      (divDone),
		.remainder (divRemainder)
	);

	always_comb begin
		next_phase               = phase;
		next_operatingTotal      = operatingTotal;
		next_timeToGo            = timeToGo;
		next_maintenanceInterval = maintenanceInterval;
		next_maintenance         = maintenance;
		next_running             = running;
		case (phase)
			mhc_pkg::PH_IDLE: begin
				next_maintenanceInterval = intervalNow;
				if (retainValid) begin
					// Retained values win over the configured offset after power loss.
					next_operatingTotal = retainTotal;
					next_timeToGo       = retainToGo;
					next_phase          = mhc_pkg::PH_RUN;
					next_running        = 1'b1;
				end else begin
					next_operatingTotal = to_minutes(offsetHours, offsetMinutes,
									 mhc_pkg::TOTAL_HOURS_W'(mhc_pkg::TOTAL_HOURS_MAX));
					next_phase          = mhc_pkg::PH_DIVIDE;
				end
			end
			mhc_pkg::PH_DIVIDE: begin
				if (divDone) begin
					// A zero interval leaves the remainder equal to the low 20 bits of the total, so load zero.
					if (maintenanceInterval == '0) begin
						next_timeToGo = '0;
					end else begin
						next_timeToGo = maintenanceInterval - divRemainder;
					end
					next_phase   = mhc_pkg::PH_RUN;
					next_running = 1'b1;
				end
			end
			mhc_pkg::PH_RUN: begin
				if (minuteTick && operatingTotal < TOTAL_LIMIT) begin
					next_operatingTotal = operatingTotal + TW'(1);
				end
				if (minuteTick && timeToGo != '0) begin
					next_timeToGo = timeToGo - IW'(1);
				end
				if (intervalNow != maintenanceInterval) begin
					next_maintenanceInterval = intervalNow;
					next_timeToGo            = intervalNow;
				end
				if (partialEdge) begin
					next_timeToGo = intervalNow;
				end
				if (fullEdge) begin
					next_operatingTotal = '0;
					next_timeToGo       = intervalNow;
				end
				// Setting is suppressed while a clearing condition holds, so clear wins.
				if (next_timeToGo == '0) begin
					next_maintenance = 1'b1;
				end
				if (partialReset || fullReset) begin
					next_maintenance = 1'b0;
				end else if (clearMode == mhc_pkg::CLEAR_RESET_OR_MON && !monitorIn) begin
					next_maintenance = 1'b0;
				end
			end
			default: begin
				next_phase = mhc_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			phase               <= mhc_pkg::PH_IDLE;
			operatingTotal      <= mhc_pkg::TOTAL_RESET;
			timeToGo            <= mhc_pkg::TOGO_RESET;
			maintenanceInterval <= mhc_pkg::TOGO_RESET;
			maintenance         <= mhc_pkg::MAINT_RESET;
			running             <= 1'b0;
			partialPrev         <= 1'b0;
			fullPrev            <= 1'b0;
		end else begin
			phase               <= next_phase;
			operatingTotal      <= next_operatingTotal;
			timeToGo            <= next_timeToGo;
			maintenanceInterval <= next_maintenanceInterval;
			maintenance         <= next_maintenance;
			running             <= next_running;
			partialPrev         <= partialReset;
			fullPrev            <= fullReset;
		end
	end
endmodule : mhc_hours_counter

/* File: mhc_hours_counter_asserts.sv */
// Concurrent checks on the ports of the maintenance hours counter.
`timescale 1ns/1ps
module mhc_hours_counter_asserts #(
	parameter longint unsigned MINUTE_CYCLES = 4
) (
	// Clock, reset and program inputs.
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        monitorIn,
	input  wire logic        partialReset,
	input  wire logic        fullReset,
	input  wire logic        clearMode,
	input  wire logic [13:0] intervalHours,
	input  wire logic [5:0]  intervalMinutes,
	// Observed outputs.
	input  wire logic        maintenance,
	input  wire logic [22:0] operatingTotal,
	input  wire logic [19:0] timeToGo,
	input  wire logic [19:0] maintenanceInterval,
	input  wire logic        running
);
	localparam int TOTAL_MAX = mhc_pkg::TOTAL_HOURS_MAX * mhc_pkg::MINUTES_PER_HOUR;
	localparam int IVL_MAX   = mhc_pkg::INTERVAL_HOURS_MAX * mhc_pkg::MINUTES_PER_HOUR + mhc_pkg::MINUTES_MAX;
	wire logic quiet = !partialReset && !fullReset;
	wire logic fixedIvl;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	assign fixedIvl = quiet;

	AST_PARTIAL_RELOAD: assert property (running && $rose(partialReset) |=> !maintenance && timeToGo == maintenanceInterval
		&& operatingTotal >= $past(operatingTotal)) else $error("partial reset did not reload");
	AST_FULL_RELOAD: assert property (running && $rose(fullReset) |=> !maintenance && operatingTotal == 0
		&& timeToGo == maintenanceInterval) else $error("full reset did not clear and reload");
	AST_IDLE_HOLD: assert property (running && !monitorIn && !$past(monitorIn) && quiet && $stable(intervalHours)
		&& $stable(intervalMinutes) |=> $stable(operatingTotal) && $stable(timeToGo)) else $error("values moved while idle");
	AST_SET_AT_ZERO: assert property (running && timeToGo == 0 && quiet && (!clearMode || monitorIn) |=> maintenance)
		else $error("output not set at zero time-to-go");
	AST_HOLD_RESET_ONLY: assert property (running && !clearMode && maintenance && quiet |=> maintenance)
		else $error("output fell without a reset");
	AST_CLEAR: assert property (running && (!quiet || (clearMode && !monitorIn)) |=> !maintenance)
		else $error("output not cleared");
	AST_INTERVAL_RANGE: assert property (maintenanceInterval <= IVL_MAX) else $error("interval out of range");
	AST_TOTAL_LIMIT: assert property (operatingTotal <= TOTAL_MAX) else $error("total above limit");
	AST_STEP_ONE: assert property ($past(running) && !$past(fullReset) && operatingTotal != $past(operatingTotal)
		|-> operatingTotal == $past(operatingTotal) + 1) else $error("total jumped");
	AST_ZERO_HOLD: assert property (running && timeToGo == 0 && fixedIvl && $stable(intervalHours)
		&& $stable(intervalMinutes) |=> timeToGo == 0) else $error("time-to-go left zero");

	cover property (running && $rose(maintenance));
	cover property (running && $rose(fullReset));
	cover property (operatingTotal == TOTAL_MAX);
endmodule : mhc_hours_counter_asserts

/* File: mhc_program_model.sv */
// Model of the controller program that drives the counter's program inputs.
`timescale 1ns/1ps
module mhc_program_model #(
	parameter int unsigned MC = 4
) (
	// Clock.
	input  wire logic        clock,
	// Program signals.
	output logic             monitorIn,
	output logic             partialReset,
	output logic             fullReset,
	output logic [13:0]      intervalHours,
	output logic [5:0]       intervalMinutes
);
	initial begin
		{monitorIn, partialReset, fullReset} = 3'h0;
		intervalHours = 14'h0000;
		intervalMinutes = 6'h00;
	end
	// Whole minutes when hold is low, so no partial minute is left behind between runs; a high hold keeps monitoring on.
	task automatic run(input int n, input bit hold);
		@(negedge clock) monitorIn = 1'b1;
		repeat (n * MC) @(negedge clock);
		monitorIn = hold;
	endtask : run
	// Changes the monitoring level at once; the caller is already on a falling edge.
	task automatic setMonitor(input bit v);
		monitorIn = v;
	endtask : setMonitor
	task automatic setReset(input bit full, input bit v);
		@(negedge clock);
		if (full) fullReset = v;
		else partialReset = v;
	endtask : setReset
	// A value taken from another block carries whole hours, so minutes stay zero.
	task automatic setHours(input logic [13:0] h);
		@(negedge clock) intervalHours = h;
		intervalMinutes = 6'h00;
	endtask : setHours
endmodule : mhc_program_model

/* File: mhc_hours_counter_test.sv */
// Self-checking testbench of the maintenance hours counter.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
	$display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module mhc_hours_counter_test;
	localparam int unsigned MC = 4;
	logic clock, reset, clearMode, retainValid, maintenance, running;
	logic monitorIn, partialReset, fullReset;
	logic [13:0] intervalHours;
	logic [5:0]  intervalMinutes, offsetMinutes;
	logic [16:0] offsetHours;
	logic [22:0] retainTotal, operatingTotal, expTotal;
	logic [19:0] retainToGo, timeToGo, maintenanceInterval, expToGo;
	int bad_count, checks_done;

	mhc_program_model #(.MC(MC)) model (.clock(clock), .monitorIn(monitorIn), .partialReset(partialReset),
		.fullReset(fullReset), .intervalHours(intervalHours), .intervalMinutes(intervalMinutes));
	mhc_hours_counter #(.MINUTE_CYCLES(MC)) uut (.clock(clock), .reset(reset), .monitorIn(monitorIn),
		.partialReset(partialReset), .fullReset(fullReset), .clearMode(clearMode), .intervalHours(intervalHours),
		.intervalMinutes(intervalMinutes), .offsetHours(offsetHours), .offsetMinutes(offsetMinutes),
		.retainValid(retainValid), .retainTotal(retainTotal), .retainToGo(retainToGo), .maintenance(maintenance),
		.operatingTotal(operatingTotal), .timeToGo(timeToGo), .maintenanceInterval(maintenanceInterval),
		.running(running));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic conclude();
		$display("counts: bad_count %0d checks_done %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic powerUp(input bit keep);
		reset = 1'b1;
		retainValid = keep;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		for (int i = 0; i < 60 && running !== 1'b1; i++) @(negedge clock);
		`CHK("running", 1'b1, running)
	endtask : powerUp
	task automatic look(input logic [22:0] t, input logic [19:0] g);
		repeat (4) @(negedge clock);
		`CHK("total", t, operatingTotal)
		`CHK("to-go", g, timeToGo)
	endtask : look

	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		conclude();
	end
	initial begin
		{reset, clearMode, retainValid} = 3'h4;
		offsetHours = 17'h00064;
		offsetMinutes = 6'h00;
		retainTotal = 23'h000000;
		retainToGo = 20'h00000;
		model.setHours(14'h001e);
		powerUp(1'b0);
		expTotal = 23'(offsetHours) * 23'(mhc_pkg::MINUTES_PER_HOUR);
		expToGo = 20'h00708 - 20'(expTotal % 23'h000708);
		look(expTotal, expToGo);
		model.run(3, 1'b0);
		look(expTotal + 23'h3, expToGo - 20'h3);
		offsetHours = 17'h00000;
		look(expTotal + 23'h3, expToGo - 20'h3);
		expTotal = expTotal + 23'h3;
		model.setHours(14'h0001);
		look(expTotal, 20'h0003c);
		`CHK("interval", 20'h0003c, maintenanceInterval)
		model.run(60, 1'b0);
		look(expTotal + 23'h3c, 20'h00000);
		`CHK("output", 1'b1, maintenance)
		model.run(2, 1'b0);
		expTotal = expTotal + 23'h3e;
		look(expTotal, 20'h00000);
		`CHK("output", 1'b1, maintenance)
		model.setReset(1'b0, 1'b1);
		model.setReset(1'b0, 1'b0);
		look(expTotal, 20'h0003c);
		`CHK("output", 1'b0, maintenance)
		model.setReset(1'b0, 1'b1);
		model.run(2, 1'b0);
		model.setReset(1'b0, 1'b0);
		expTotal = expTotal + 23'h2;
		look(expTotal, 20'h0003a);
		clearMode = 1'b1;
		model.run(58, 1'b1);
		repeat (3) @(negedge clock);
		`CHK("output", 1'b1, maintenance)
		model.setMonitor(1'b0);
		look(expTotal + 23'h3a, 20'h00000);
		`CHK("output", 1'b0, maintenance)
		model.setReset(1'b1, 1'b1);
		model.setReset(1'b1, 1'b0);
		look(23'h000000, 20'h0003c);
		retainTotal = 23'(mhc_pkg::TOTAL_HOURS_MAX * mhc_pkg::MINUTES_PER_HOUR - 1);
		retainToGo = 20'h00005;
		powerUp(1'b1);
		look(retainTotal, retainToGo);
		model.run(3, 1'b0);
		look(retainTotal + 23'h1, 20'h00002);
		model.setHours(14'h3fff);
		expToGo = 20'(mhc_pkg::INTERVAL_HOURS_MAX * mhc_pkg::MINUTES_PER_HOUR);
		look(retainTotal + 23'h1, expToGo);
		`CHK("interval", expToGo, maintenanceInterval)
		conclude();
	end
endmodule : mhc_hours_counter_test
bind mhc_hours_counter mhc_hours_counter_asserts #(.MINUTE_CYCLES(MINUTE_CYCLES)) checks (.clock(clock), .reset(reset),
	.monitorIn(monitorIn), .partialReset(partialReset), .fullReset(fullReset), .clearMode(clearMode),
	.intervalHours(intervalHours), .intervalMinutes(intervalMinutes), .maintenance(maintenance),
	.operatingTotal(operatingTotal), .timeToGo(timeToGo), .maintenanceInterval(maintenanceInterval), .running(running));
